// ---- src/scg_serial_cmd.sv ----
// Serial command decoder: DAC select, reset/control and pin commands
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Byte 0001XXXX selects DAC; the next 16-bit word goes to the DAC path.
// - Byte 00001xxx writes reset/control; bits 2:0 carry the settings.
// - Bit 2 zero clears the result FIFO and loads bits 1:0; one restores power-on state.
// - Power-up and full reset leave the pin, DAC word and control registers at zero.
// - Slow bit adds about 15ns to the output path and clears the FIFO.
// - Force-bandgap keeps bias and bandgap powered regardless of activity.
// - Force-bandgap skips the wake-up delay in clock modes 01 and 11.
// - Setting force-bandgap also clears the result FIFO.
// - Bits 7:2 zero mean pin command; bits 1:0 are 11 configure, 10 write, 01 read.
// - 00000011 configure, 00000010 write output, 00000001 read pins.
// - Configure takes 8 or 16 further bits into the direction register.
// - Pin write takes 8 or 16 further bits into the output register.
// - Pin registers change only on full reset or at the chip-select rise ending the frame.
// - After power-up every pin is an input until reconfigured.
// - Pin data MSB first: C, B, A ports high to low, then four spare bits.
// - Readback shows the pin states on DOUT for the next 8 or 16 bits.
// - DAC word is 16 bits: four control bits, then twelve data bits.
module scg_serial_cmd (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CS_N,
  input  wire logic        SCLK,
  input  wire logic        DIN,
  input  wire logic        VARIANT_WIDE,
  input  wire logic [11:0] GPIO_IN,
  input  wire logic [1:0]  CLOCK_MODE,
  output logic             DOUT,
  output logic      [11:0] GPIO_OUT,
  output logic      [11:0] GPIO_OE,
  output logic      [15:0] DAC_WORD,
  output logic             DAC_WORD_VALID,
  output logic             FIFO_CLEAR,
  output logic             DEVICE_RESET,
  output logic             FORCE_BANDGAP,
  output logic             SKIP_WAKE_DELAY,
  output logic             SLOW_MODE
);

  localparam int DLY_W = scg_pkg::SLOW_DELAY_CYC;

  logic [scg_pkg::SYNC_W-1:0] sync_vec;
  logic                       cs_n_s;
  logic                       sclk_s;
  logic                       din_s;
  logic                       wide_s;
  logic [11:0]                pins_s;

  // Every pin input except SYS_RST and CLOCK_MODE passes two flops before use
  scg_sync #(
    .WIDTH (scg_pkg::SYNC_W)
  ) u_sync (
    .clk      (CLK),
    .rst      (SYS_RST),
    .async_in ({CS_N, SCLK, DIN, VARIANT_WIDE, GPIO_IN}),
    .sync_out (sync_vec)
  );

  assign cs_n_s = sync_vec[scg_pkg::SYNC_W-1];
  assign sclk_s = sync_vec[scg_pkg::SYNC_W-2];
  assign din_s  = sync_vec[scg_pkg::SYNC_W-3];
  assign wide_s = sync_vec[scg_pkg::SYNC_W-4];
  assign pins_s = sync_vec[11:0];

  logic                sclk_prev_reg;
  logic                cs_prev_reg;
  scg_pkg::scg_state_t state_reg;
  scg_pkg::scg_state_t state_next;
  logic [4:0]          fcnt_reg;
  logic [4:0]          fcnt_next;
  logic [15:0]         din_sh_reg;
  logic [15:0]         din_sh_next;
  logic [15:0]         out_sh_reg;
  logic [15:0]         out_sh_next;
  logic [11:0]         stage_reg;
  logic [11:0]         stage_next;
  logic                pend_cfg_reg;
  logic                pend_cfg_next;
  logic                pend_wr_reg;
  logic                pend_wr_next;
  logic [11:0]         pin_cfg_reg;
  logic [11:0]         pin_cfg_next;
  logic [11:0]         pin_out_reg;
  logic [11:0]         pin_out_next;
  logic                slow_reg;
  logic                slow_next;
  logic                fbg_reg;
  logic                fbg_next;
  logic [15:0]         dac_word_reg;
  logic [15:0]         dac_word_next;
  logic                dac_valid_reg;
  logic                dac_valid_next;
  logic                fifo_clr_reg;
  logic                fifo_clr_next;
  logic                dev_rst_reg;
  logic                dev_rst_next;
  logic                dout_bit_reg;
  logic                dout_bit_next;
  logic [DLY_W-1:0]    dly_reg;
  logic [DLY_W-1:0]    dly_next;
  logic                dout_reg;
  logic                dout_next;
  logic                skip_reg;
  logic                skip_next;

  logic                sclk_fall;
  logic                sclk_rise;
  logic                cs_rise;
  logic [15:0]         din_shifted;
  logic [4:0]          fcnt_inc;
  logic [4:0]          dlen;
  logic [7:0]          cmd;
  logic [11:0]         unpacked;
  logic [15:0]         packed_pins;

  // Edges of the sampled link signals
  assign sclk_fall   = sclk_prev_reg & ~sclk_s;
  assign sclk_rise   = ~sclk_prev_reg & sclk_s;
  assign cs_rise     = ~cs_prev_reg & cs_n_s;
  assign din_shifted = {din_sh_reg[14:0], din_s};
  assign fcnt_inc    = fcnt_reg + scg_pkg::FCNT_ONE;
  assign cmd         = din_shifted[7:0];
  assign dlen        = wide_s ? scg_pkg::DATA_BITS_WIDE
                              : scg_pkg::DATA_BITS_NARROW;

  // Data bits to pin register, per variant
  assign unpacked = wide_s ? din_shifted[scg_pkg::WIDE_LSB +: 12]
    : {2'h0, din_shifted[scg_pkg::NARROW_LSB + 2 +: 2], 6'h00,
       din_shifted[scg_pkg::NARROW_LSB +: 2]};

  // Pin states to readback word, MSB first, spare bits zero
  assign packed_pins = wide_s ? {pins_s, 4'h0}
    : {pins_s[scg_pkg::PIN_C1], pins_s[scg_pkg::PIN_C0],
       pins_s[scg_pkg::PIN_A1], pins_s[scg_pkg::PIN_A0], 12'h000};

  // Frame decoder and register file next state
  always_comb
  begin
    state_next     = state_reg;
    fcnt_next      = fcnt_reg;
    din_sh_next    = din_sh_reg;
    out_sh_next    = out_sh_reg;
    stage_next     = stage_reg;
    pend_cfg_next  = pend_cfg_reg;
    pend_wr_next   = pend_wr_reg;
    pin_cfg_next   = pin_cfg_reg;
    pin_out_next   = pin_out_reg;
    slow_next      = slow_reg;
    fbg_next       = fbg_reg;
    dac_word_next  = dac_word_reg;
    dac_valid_next = 1'b0;
    fifo_clr_next  = 1'b0;
    dev_rst_next   = 1'b0;
    dout_bit_next  = dout_bit_reg;
    dly_next       = {dly_reg[DLY_W-2:0], dout_bit_reg}; // Slow tap line
    dout_next      = slow_reg ? dly_reg[DLY_W-1] : dout_bit_reg;
    skip_next      = fbg_reg & CLOCK_MODE[scg_pkg::CLK_MODE_SKIP_BIT];
    if (cs_n_s)
    begin
      // Deselected: restart decoding; the rise applies staged pin data
      state_next    = scg_pkg::ST_CMD;
      fcnt_next     = scg_pkg::FCNT_ZERO;
      dout_bit_next = 1'b0;
      if (cs_rise && pend_cfg_reg)
        pin_cfg_next = stage_reg;
      if (cs_rise && pend_wr_reg)
        pin_out_next = stage_reg;
      pend_cfg_next = 1'b0;
      pend_wr_next  = 1'b0;
    end
    else if (sclk_fall && state_reg != scg_pkg::ST_HOLD)
    begin
      din_sh_next = din_shifted;
      fcnt_next   = fcnt_inc;
      case (state_reg)
        scg_pkg::ST_CMD:
        begin
          if (fcnt_inc == scg_pkg::CMD_BITS)
          begin
            fcnt_next = scg_pkg::FCNT_ZERO;
            if (cmd[7:4] == scg_pkg::DAC_SEL_HI)
              state_next = scg_pkg::ST_DAC;
            else if (cmd[7:3] == scg_pkg::RST_SEL_HI)
            begin
              fifo_clr_next = 1'b1;
              if (cmd[scg_pkg::RST_FULL_BIT])
              begin
                dev_rst_next  = 1'b1;
                pin_cfg_next  = scg_pkg::PIN_CFG_RST;
                pin_out_next  = scg_pkg::PIN_OUT_RST;
                stage_next    = scg_pkg::PIN_CFG_RST;
                dac_word_next = scg_pkg::WORD_RST;
                slow_next     = 1'b0;
                fbg_next      = 1'b0;
              end
              else
              begin
                slow_next = cmd[scg_pkg::RST_SLOW_BIT];
                fbg_next  = cmd[scg_pkg::RST_FBG_BIT];
              end
            end
            else if (cmd[7:2] == scg_pkg::PIN_SEL_HI)
            begin
              case (cmd[1:0])
                scg_pkg::PIN_CODE_CFG: state_next = scg_pkg::ST_CFG;
                scg_pkg::PIN_CODE_WR:  state_next = scg_pkg::ST_WR;
                scg_pkg::PIN_CODE_RD:
                begin
                  state_next  = scg_pkg::ST_RD;
                  out_sh_next = packed_pins;
                end
                default:               state_next = scg_pkg::ST_CMD;
              endcase
            end
          end
        end
        scg_pkg::ST_DAC:
        begin
          if (fcnt_inc == scg_pkg::DAC_BITS)
          begin
            dac_word_next  = din_shifted;
            dac_valid_next = 1'b1;
            state_next     = scg_pkg::ST_CMD;
            fcnt_next      = scg_pkg::FCNT_ZERO;
          end
        end
        scg_pkg::ST_CFG,
        scg_pkg::ST_WR:
        begin
          if (fcnt_inc == dlen)
          begin
            stage_next    = unpacked;
            pend_cfg_next = (state_reg == scg_pkg::ST_CFG);
            pend_wr_next  = (state_reg == scg_pkg::ST_WR);
            state_next    = scg_pkg::ST_HOLD;
          end
        end
        scg_pkg::ST_RD:
        begin
          if (fcnt_inc == dlen)
          begin
            state_next = scg_pkg::ST_CMD;
            fcnt_next  = scg_pkg::FCNT_ZERO;
          end
        end
        default:
          state_next = scg_pkg::ST_CMD;
      endcase
    end
    else if (sclk_rise && state_reg == scg_pkg::ST_RD)
    begin
      // Readback bits change on rising SCLK
      dout_bit_next = out_sh_reg[15];
      out_sh_next   = {out_sh_reg[14:0], 1'b0};
    end
    else if (sclk_rise)
      dout_bit_next = 1'b0;
  end

  // Frame decoder and register file flops
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
      state_reg     <= scg_pkg::ST_CMD;
      fcnt_reg      <= scg_pkg::FCNT_ZERO;
      din_sh_reg    <= scg_pkg::WORD_RST;
      out_sh_reg    <= scg_pkg::WORD_RST;
      stage_reg     <= scg_pkg::PIN_CFG_RST;
      pend_cfg_reg  <= 1'b0;
      pend_wr_reg   <= 1'b0;
      pin_cfg_reg   <= scg_pkg::PIN_CFG_RST;
      pin_out_reg   <= scg_pkg::PIN_OUT_RST;
      slow_reg      <= 1'b0;
      fbg_reg       <= 1'b0;
      dac_word_reg  <= scg_pkg::WORD_RST;
      dac_valid_reg <= 1'b0;
      fifo_clr_reg  <= 1'b0;
      dev_rst_reg   <= 1'b0;
      dout_bit_reg  <= 1'b0;
      dly_reg       <= '0;
      dout_reg      <= 1'b0;
      skip_reg      <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= sclk_s;
      cs_prev_reg   <= cs_n_s;
      state_reg     <= state_next;
      fcnt_reg      <= fcnt_next;
      din_sh_reg    <= din_sh_next;
      out_sh_reg    <= out_sh_next;
      stage_reg     <= stage_next;
      pend_cfg_reg  <= pend_cfg_next;
      pend_wr_reg   <= pend_wr_next;
      pin_cfg_reg   <= pin_cfg_next;
      pin_out_reg   <= pin_out_next;
      slow_reg      <= slow_next;
      fbg_reg       <= fbg_next;
      dac_word_reg  <= dac_word_next;
      dac_valid_reg <= dac_valid_next;
      fifo_clr_reg  <= fifo_clr_next;
      dev_rst_reg   <= dev_rst_next;
      dout_bit_reg  <= dout_bit_next;
      dly_reg       <= dly_next;
      dout_reg      <= dout_next;
      skip_reg      <= skip_next;
    end
  end

  // Port drive: direction bit one drives the output register value
  assign DOUT            = dout_reg;
  assign GPIO_OE         = pin_cfg_reg;
  assign GPIO_OUT        = pin_out_reg;
  assign DAC_WORD        = dac_word_reg;
  assign DAC_WORD_VALID  = dac_valid_reg;
  assign FIFO_CLEAR      = fifo_clr_reg;
  assign DEVICE_RESET    = dev_rst_reg;
  assign FORCE_BANDGAP   = fbg_reg;
  assign SKIP_WAKE_DELAY = skip_reg;
  assign SLOW_MODE       = slow_reg;

endmodule
`default_nettype wire

// ---- src/scg_pkg.sv ----
// Constants and types for the serial command decoder
package scg_pkg;

  // Field lengths in SCLK cycles
  localparam logic [4:0] CMD_BITS         = 5'h08;
  localparam logic [4:0] DAC_BITS         = 5'h10;
  localparam logic [4:0] DATA_BITS_NARROW = 5'h08;
  localparam logic [4:0] DATA_BITS_WIDE   = 5'h10;
  localparam logic [4:0] FCNT_ZERO        = 5'h00;
  localparam logic [4:0] FCNT_ONE         = 5'h01;

  // Command byte selector fields
  localparam logic [3:0] DAC_SEL_HI   = 4'h1;  // Bits 7:4
  localparam logic [4:0] RST_SEL_HI   = 5'h01; // Bits 7:3
  localparam logic [5:0] PIN_SEL_HI   = 6'h00; // Bits 7:2
  localparam logic [1:0] PIN_CODE_CFG = 2'h3;
  localparam logic [1:0] PIN_CODE_WR  = 2'h2;
  localparam logic [1:0] PIN_CODE_RD  = 2'h1;

  // Reset/control command bit positions
  localparam int RST_FULL_BIT = 2;
  localparam int RST_SLOW_BIT = 1;
  localparam int RST_FBG_BIT  = 0;

  // Clock modes 01 and 11 share a set low bit
  localparam int CLK_MODE_SKIP_BIT = 0;

  // Pin register layout: port A 3:0, port B 7:4, port C 11:8
  localparam int PIN_COUNT  = 12;
  localparam int PIN_A0     = 0;
  localparam int PIN_A1     = 1;
  localparam int PIN_C0     = 8;
  localparam int PIN_C1     = 9;
  localparam int WIDE_LSB   = 4;  // Data bits 15:4 carry pins 11:0
  localparam int NARROW_LSB = 4;  // Data bits 7:4 carry C1 C0 A1 A0

  // Power-on values
  localparam logic [11:0] PIN_CFG_RST = 12'h000;
  localparam logic [11:0] PIN_OUT_RST = 12'h000;
  localparam logic [15:0] WORD_RST    = 16'h0000;

  // Slow output path delay
  localparam int CLK_PERIOD_NS  = 8;
  localparam int SLOW_DELAY_NS  = 15;
  localparam int SLOW_DELAY_CYC =
    (SLOW_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Synchroniser width: CS_N, SCLK, DIN, VARIANT_WIDE, pins
  localparam int SYNC_W = 4 + PIN_COUNT;

  // Frame decoder states
  typedef enum logic [2:0] {
    ST_CMD,
    ST_DAC,
    ST_CFG,
    ST_WR,
    ST_RD,
    ST_HOLD
  } scg_state_t;

endpackage

// ---- src/scg_sync.sv ----
// Two-flop synchroniser for a bus of independent levels
`timescale 1ns/1ns
`default_nettype none
module scg_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // First stage feeds only the second stage
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule
`default_nettype wire

// ---- testbench/scg_serial_cmd_properties.sv ----
// Port checks for the serial command decoder
`timescale 1ns/1ns
`default_nettype none
module scg_serial_cmd_properties (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        CS_N,
  input wire logic        SCLK,
  input wire logic [1:0]  CLOCK_MODE,
  input wire logic        DOUT,
  input wire logic [11:0] GPIO_OUT,
  input wire logic [11:0] GPIO_OE,
  input wire logic [15:0] DAC_WORD,
  input wire logic        DAC_WORD_VALID,
  input wire logic        FIFO_CLEAR,
  input wire logic        DEVICE_RESET,
  input wire logic        FORCE_BANDGAP,
  input wire logic        SKIP_WAKE_DELAY,
  input wire logic        SLOW_MODE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Frame phases seen at the pins
  sequence cs_idle;
    CS_N [*8];
  endsequence
  sequence clk_parked;
    (!SCLK && !CS_N) [*8];
  endsequence
  sequence mid_frame;
    (!CS_N && !DEVICE_RESET) [*4];
  endsequence

  // Power-on values after each reset, then the wake delay skip
  chk_reset_clears: assert property (
    $fell(SYS_RST) |-> GPIO_OE == 12'h000 && GPIO_OUT == 12'h000
      && !DOUT && !SLOW_MODE && !FORCE_BANDGAP)
    else $error("outputs not cleared by reset");
  chk_skip_follows: assert property (
    SKIP_WAKE_DELAY == $past(FORCE_BANDGAP && CLOCK_MODE[0]))
    else $error("wake delay skip wrong");
  // Control command side effects
  chk_full_clear: assert property (
    DEVICE_RESET |-> FIFO_CLEAR
      ##[1:3] (GPIO_OE == 12'h000 && !FORCE_BANDGAP && !SLOW_MODE))
    else $error("full reset incomplete");
  chk_clear_pulse: assert property (
    FIFO_CLEAR |=> !FIFO_CLEAR)
    else $error("fifo clear longer than a cycle");
  chk_fbg_clears: assert property (
    $rose(FORCE_BANDGAP) |-> FIFO_CLEAR || $past(FIFO_CLEAR))
    else $error("bandgap set without fifo clear");
  chk_slow_clears: assert property (
    $rose(SLOW_MODE) |-> FIFO_CLEAR || $past(FIFO_CLEAR))
    else $error("slow mode set without fifo clear");
  // Data word, pin registers and serial out
  chk_dac_update: assert property (
    $changed(DAC_WORD) |-> DAC_WORD_VALID || DEVICE_RESET
      || $past(DEVICE_RESET))
    else $error("dac word changed without strobe");
  chk_pin_hold: assert property (
    mid_frame |-> $stable(GPIO_OE) && $stable(GPIO_OUT))
    else $error("pin register changed inside frame");
  chk_dout_idle: assert property (
    cs_idle |-> !DOUT)
    else $error("serial out active while deselected");
  chk_dout_steady: assert property (
    clk_parked |-> $stable(DOUT))
    else $error("serial out moved without clock rise");
endmodule

bind scg_serial_cmd scg_serial_cmd_properties scg_serial_cmd_properties_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SCLK(SCLK),
  .CLOCK_MODE(CLOCK_MODE), .DOUT(DOUT), .GPIO_OUT(GPIO_OUT),
  .GPIO_OE(GPIO_OE), .DAC_WORD(DAC_WORD), .DAC_WORD_VALID(DAC_WORD_VALID),
  .FIFO_CLEAR(FIFO_CLEAR), .DEVICE_RESET(DEVICE_RESET),
  .FORCE_BANDGAP(FORCE_BANDGAP), .SKIP_WAKE_DELAY(SKIP_WAKE_DELAY),
  .SLOW_MODE(SLOW_MODE)
);
`default_nettype wire

// ---- testbench/scg_host_model.sv ----
// Serial host that frames commands with chip select
`timescale 1ns/1ns
`default_nettype none
module scg_host_model (
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  // Idle: deselected, clock parked low
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
    din = 1'h0;
  end

  // One framed transfer, MSB first, output taken at each falling edge
  task automatic frame(input logic [47:0] tx, input int n,
                       output logic [47:0] rx);
    rx = 48'h0;
    cs_n = 1'h0;
    #125;
    for (int i = n - 1; i >= 0; i--)
    begin
      din = tx[i];
      sclk = 1'h1;
      #62;
      rx = {rx[46:0], dout};
      sclk = 1'h0;
      #63;
    end
    cs_n = 1'h1;
    din = ~din; // Released line shows no stale bit
    #250;
  endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench for the serial command decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        CLK, SYS_RST, VARIANT_WIDE, CS_N, SCLK, DIN, DOUT;
  logic        DAC_WORD_VALID, FIFO_CLEAR, DEVICE_RESET;
  logic        FORCE_BANDGAP, SKIP_WAKE_DELAY, SLOW_MODE, m_slow, m_fbg;
  logic [1:0]  CLOCK_MODE;
  logic [11:0] GPIO_IN, GPIO_OUT, GPIO_OE, m_oe, m_out;
  logic [15:0] DAC_WORD, m_dac, d;
  logic [47:0] rx;
  int          num_errors, n_tests, n_clr, n_rst, n_dac, w, v, k, j;

  scg_serial_cmd scg_serial_cmd_i (
    .CLK(CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN),
    .VARIANT_WIDE(VARIANT_WIDE), .GPIO_IN(GPIO_IN),
    .CLOCK_MODE(CLOCK_MODE), .DOUT(DOUT), .GPIO_OUT(GPIO_OUT),
    .GPIO_OE(GPIO_OE), .DAC_WORD(DAC_WORD),
    .DAC_WORD_VALID(DAC_WORD_VALID), .FIFO_CLEAR(FIFO_CLEAR),
    .DEVICE_RESET(DEVICE_RESET), .FORCE_BANDGAP(FORCE_BANDGAP),
    .SKIP_WAKE_DELAY(SKIP_WAKE_DELAY), .SLOW_MODE(SLOW_MODE)
  );
  scg_host_model scg_host_model_i (
    .cs_n(CS_N), .sclk(SCLK), .din(DIN), .dout(DOUT)
  );

  // System clock
  initial
  begin
    CLK = 1'h0;
    forever #4 CLK = ~CLK;
  end

  // Pulse counters
  always @(posedge CLK)
  begin
    if (FIFO_CLEAR === 1'h1) n_clr++;
    if (DEVICE_RESET === 1'h1) n_rst++;
    if (DAC_WORD_VALID === 1'h1) n_dac++;
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge CLK);
    num_errors++;
    test_done;
  end

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Pin data as laid out for the strapped variant
  function automatic logic [11:0] pin_map(input logic [15:0] x);
    return w[0] ? x[15:4] : {2'h0, x[15:14], 6'h00, x[13:12]};
  endfunction

  task automatic check_all;
    cmp({4'h0, GPIO_OE}, {4'h0, m_oe});
    cmp({4'h0, GPIO_OUT}, {4'h0, m_out});
    cmp({14'h0, SLOW_MODE, FORCE_BANDGAP}, {14'h0, m_slow, m_fbg});
  endtask

  // Optional prefix, pin command, random data; model follows
  task automatic pin_frame(input logic [23:0] pre, input int pn,
                           input logic [7:0] c);
    logic [47:0] t;
    int          q;
    d = 16'($urandom);
    t = {8'h00, pre, c, d};
    if (!w[0])
      t = t >> 8;
    q = n_dac;
    scg_host_model_i.frame(t, pn + (w[0] ? 24 : 16), rx);
    if (c == 8'h03) m_oe = pin_map(d);
    if (c == 8'h02) m_out = pin_map(d);
    if (pn == 24) m_dac = pre[15:0];
    cmp(16'(n_dac - q), {15'h0, pn == 24});
    cmp(DAC_WORD, m_dac);
    if (c == 8'h01)
      cmp(rx[15:0], w[0] ? {GPIO_IN, 4'h0} :
          {8'h00, GPIO_IN[9:8], GPIO_IN[1:0], 4'h0});
    check_all;
  endtask

  // Main sequence, once per pin variant
  initial
  begin
    {num_errors, n_tests, n_clr, n_rst, n_dac} = 0;
    {SYS_RST, VARIANT_WIDE, GPIO_IN, CLOCK_MODE} = 16'h8000;
    d = 16'($urandom(32'hA61C));
    for (w = 0; w < 2; w++)
    begin
      @(negedge CLK);
      VARIANT_WIDE = w[0];
      SYS_RST = 1'h1;
      repeat (3) @(negedge CLK);
      SYS_RST = 1'h0;
      repeat (4) @(negedge CLK);
      {m_oe, m_out, m_slow, m_fbg, m_dac} = 42'h0;
      check_all;
      GPIO_IN = 12'($urandom);
      pin_frame(24'h0, 0, 8'h03);
      pin_frame(24'h0, 0, 8'h02);
      pin_frame(24'h0, 0, 8'h01);
      pin_frame({8'h10 | 8'($urandom % 16), 16'($urandom)}, 24, 8'h01);
      scg_host_model_i.frame({32'h0, 8'h1F, 8'hA5}, 16, rx);
      cmp(DAC_WORD, m_dac);
      pin_frame({16'h0, 8'h20}, 8, 8'h02);
      for (v = 0; v < 8; v++)
      begin
        @(negedge CLK);
        CLOCK_MODE = {1'($urandom), v[1]}; // Both skip cases reached
        k = n_clr;
        j = n_rst;
        scg_host_model_i.frame({40'h0, 8'h08 | 8'(v)}, 8, rx);
        cmp(16'(n_clr - k), 16'h0001);
        cmp(16'(n_rst - j), {15'h0, v[2]});
        if (v[2])
          {m_oe, m_out, m_slow, m_fbg, m_dac} = 42'h0;
        else
          {m_slow, m_fbg} = v[1:0];
        check_all;
        cmp({15'h0, SKIP_WAKE_DELAY}, {15'h0, m_fbg & CLOCK_MODE[0]});
      end
      scg_host_model_i.frame({40'h0, 8'h0A}, 8, rx);
      m_slow = 1'h1;
      pin_frame(24'h0, 0, 8'h01);
    end
    test_done;
  end
endmodule
`default_nettype wire
